// *** bcp_defines.svh ***
/*
 * Constants of the commutation and protection block: clock rate, times,
 * register offsets, field positions and reset values.
 * Assumes a 100 MHz system clock; included by its bare name.
 */
`ifndef BCP_DEFINES_SVH
`define BCP_DEFINES_SVH

// System clock period in ns
`define BCP_CLK_PERIOD_NS      10
// Nominal speed pulse width in ns
`define BCP_TACH_PULSE_NS      113000
// Brake hold after supply comes up, in ns
`define BCP_START_BRAKE_NS     200000
// Derived cycle counts, rounded up to whole cycles
`define BCP_TACH_CYCLES   ((`BCP_TACH_PULSE_NS + `BCP_CLK_PERIOD_NS - 1) / `BCP_CLK_PERIOD_NS)
`define BCP_BRAKE_CYCLES  ((`BCP_START_BRAKE_NS + `BCP_CLK_PERIOD_NS - 1) / `BCP_CLK_PERIOD_NS)

// Register byte offsets
`define BCP_CTRL_OFS           8'h00
`define BCP_STATUS_OFS         8'h04
`define BCP_EVENT_OFS          8'h08

// Control register fields and reset value
`define BCP_CTRL_ENABLE_BIT    0
`define BCP_CTRL_COAST_BIT     1
`define BCP_CTRL_RST           2'h1

// Event register fields (write one to clear)
`define BCP_EVT_ILLEGAL_BIT    0
`define BCP_EVT_OVERCUR_BIT    1
`define BCP_EVT_DIRMIS_BIT     2

`endif

// *** bcp_pkg.sv ***
/*
 * Types of the commutation and protection block.
 * Assumes bcp_defines.svh carries the numeric constants.
 */
package bcp_pkg;

	// Role of one motor phase
	typedef enum logic [1:0] {
		BCP_ROLE_HIZ,
		BCP_ROLE_SOURCE,
		BCP_ROLE_SINK
	} bcp_role_t;

	// Roles of phases A (index 2), B (1), C (0)
	typedef bcp_role_t [2:0] bcp_roles_t;

	// Output stage selection
	typedef enum logic [1:0] {
		BCP_MODE_RUN,
		BCP_MODE_BRAKE,
		BCP_MODE_COAST,
		BCP_MODE_HIZ
	} bcp_mode_t;

	// Six gate enables, phase A at index 2
	typedef struct packed {
		logic [2:0] high;
		logic [2:0] low;
	} bcp_gate_t;

	// Pin and comparator inputs, all asynchronous to the clock
	typedef struct packed {
		logic [2:0] hall;          // First position input at bit 2
		logic       direction;     // Requested direction
		logic       quad_select;   // High selects full control chopping
		logic       speed_below;   // Speed input under its threshold
		logic       brake_timing;  // Brake timing input under its threshold
		logic       shutdown_coast;// Coast input over its inhibit threshold
		logic       undervoltage;  // Supply under its turn-on level
		logic       overcurrent;   // Overcurrent comparator tripped
		logic       restart_below; // Soft-start capacitor under restart level
		logic       pwm_trip;      // PWM comparator tripped
		logic       osc;           // PWM oscillator square wave
	} bcp_pins_t;

endpackage

// *** bcp_sync.sv ***
/*
 * Two flip-flop synchroniser for a bundle of level inputs.
 * Assumes the inputs change slowly against the clock; only the second
 * stage is offered to logic.
 */
module bcp_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input  wire logic             clock_in,
	input  wire logic             resetn_in,
	input  wire logic             ce_in,
	// Data
	input  wire logic [WIDTH-1:0] data_in,
	output logic      [WIDTH-1:0] data_out
);

	logic [WIDTH-1:0] meta_ff;    // First stage, read only by second stage

	// Two stages, frozen with the clock enable
	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			meta_ff  <= '0;
			data_out <= '0;
		end else if (ce_in) begin
			meta_ff  <= data_in;
			data_out <= meta_ff;
		end
	end

endmodule // bcp_sync

// *** bcp_timer.sv ***
/*
 * One-shot timer: a start pulse raises busy for exactly load_in cycles.
 * Assumes load_in is at least one and start_in is a one-cycle pulse.
 */
module bcp_timer (
	// Clock and reset
	input  wire logic        clock_in,
	input  wire logic        resetn_in,
	input  wire logic        ce_in,
	// Control
	input  wire logic        start_in,
	input  wire logic [15:0] load_in,
	// Status
	output logic             busy_out
);

	logic [15:0] count_ff;        // Cycles left after this one

	// A restart while busy reloads the full width
	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			count_ff <= 16'h0000;
			busy_out <= 1'b0;
		end else if (ce_in) begin
			if (start_in) begin
				count_ff <= load_in - 16'h0001;
				busy_out <= 1'b1;
			end else if (count_ff != 16'h0000) begin
				count_ff <= count_ff - 16'h0001;
			end else begin
				busy_out <= 1'b0;
			end
		end
	end

endmodule // bcp_timer

// *** bcp_commutation.sv ***
/*
 * Commutation and protection logic of a three-phase brushless motor driver,
 * with an AHB-Lite register slave for control, status and sticky events.
 * Assumes all pin inputs are asynchronous, the oscillator input rises
 * once per PWM period, and reset comes from supply supervision.
 */
// Local design decisions: the AHB-Lite slave port and the register addresses.
// Notes on behaviour
// - Select low: only low-side switches chop
// - Select high: all active switches chop
// - Select change ignored while braking
// - Hall change emits one fixed speed pulse
// - Hall latches frozen during speed pulse
// - Brake: highs off, lows on
// - Coast: all six drivers off
// - Undervoltage or overcurrent sets soft-start, discharge
// - Clear soft-start when capacitor low, no fault
// - Direction latch transparent only at low speed
// - Latched direction passes two shift stages
// - Any direction stage mismatch forces Hi-Z
// - Shift stages advance on oscillator ticks only
// - Legal code: one source, one sink, one open
// - All zeros or ones: all phases open
// - Brake held about 200 us after supply
// - PWM comparator trip clears PWM latch
`include "bcp_defines.svh"

module bcp_commutation #(
	parameter logic [15:0] TACH_CYCLES  = 16'(`BCP_TACH_CYCLES),
	parameter logic [15:0] BRAKE_CYCLES = 16'(`BCP_BRAKE_CYCLES)
) (
	// Clock, reset, enable
	input  wire logic              clock_in,
	input  wire logic              resetn_in,
	input  wire logic              ce_in,
	// Pins and comparators
	input  wire bcp_pkg::bcp_pins_t pins_in,
	// AHB-Lite slave
	input  wire logic              hsel_in,
	input  wire logic [31:0]       haddr_in,
	input  wire logic [1:0]        htrans_in,
	input  wire logic              hwrite_in,
	input  wire logic [2:0]        hsize_in,
	input  wire logic [31:0]       hwdata_in,
	input  wire logic              hready_in,
	output logic      [31:0]       hrdata_out,
	output logic                   hreadyout_out,
	output logic                   hresp_out,
	// Drivers and indications
	output bcp_pkg::bcp_gate_t     gate_out,
	output logic                   tach_out,
	output logic                   discharge_out
);
	import bcp_pkg::*;

	bcp_pins_t  s;                // Synchronised inputs
	logic [2:0] hall_ff;          // Hall position latches
	logic       tach_start;       // Accepted position change
	logic       osc_d_ff;         // Previous oscillator level
	logic       osc_tick;         // One cycle per PWM period
	logic       dir_latch_ff;     // Direction latch
	logic [1:0] dir_sr_ff;        // Direction shift register, [1] feeds decoder
	logic       dir_mismatch;     // Some direction stage disagrees
	logic       pwm_on_ff;        // PWM latch, high during on-portion
	logic       quad_ff;          // Chopping regime in effect
	logic       start_done_ff;    // Startup brake timer launched
	logic       start_busy;       // Startup brake running
	logic       brake_active;     // Brake request or startup hold
	logic       illegal;          // Hall code without a commutation step
	logic [1:0] ctrl_ff;          // Enable and software coast
	logic [2:0] evt_ff;           // Sticky events
	logic       wr_pend_ff;       // Write data phase pending
	logic [7:0] wr_addr_ff;       // Offset of pending write
	logic       addr_ok;          // Valid address phase this cycle
	bcp_mode_t  mode;             // Output stage selection
	bcp_roles_t roles;            // Decoded phase roles
	bcp_gate_t  nxt_gate;         // Next gate enables
	logic [31:0] nxt_rdata;       // Read value for the addressed register
	logic [2:0] evt_clr;          // Event bits cleared by software

	// All pin inputs are asynchronous; nothing reads them unsynchronised
	bcp_sync #(.WIDTH($bits(bcp_pins_t))) u_sync (
		.clock_in  (clock_in),
		.resetn_in (resetn_in),
		.ce_in     (ce_in),
		.data_in   (pins_in),
		.data_out  (s)
	);

	// Oscillator rising edge marks a new PWM period
	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			osc_d_ff <= 1'b0;
		end else if (ce_in) begin
			osc_d_ff <= s.osc;
		end
	end
	assign osc_tick = s.osc & ~osc_d_ff;

	// A change is taken only when no pulse runs, so noise is rejected
	assign tach_start = (s.hall != hall_ff) & ~tach_out;

	// Hall latches freeze while the speed pulse is high
	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			hall_ff <= 3'h0;
		end else if (ce_in && tach_start) begin
			hall_ff <= s.hall;
		end
	end

	// Speed pulse; limits top commutation rate to one per pulse width
	bcp_timer u_tach (
		.clock_in  (clock_in),
		.resetn_in (resetn_in),
		.ce_in     (ce_in),
		.start_in  (ce_in & tach_start),
		.load_in   (TACH_CYCLES),
		.busy_out  (tach_out)
	);

	// Launch the startup brake hold once after reset release
	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			start_done_ff <= 1'b0;
		end else if (ce_in) begin
			start_done_ff <= 1'b1;
		end
	end

	// Startup hold lets bootstrap capacitors charge through the lows
	bcp_timer u_start (
		.clock_in  (clock_in),
		.resetn_in (resetn_in),
		.ce_in     (ce_in),
		.start_in  (~start_done_ff),
		.load_in   (BRAKE_CYCLES),
		.busy_out  (start_busy)
	);
	assign brake_active = s.brake_timing | start_busy | ~start_done_ff;

	// Direction latch passes input only at low speed
	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			dir_latch_ff <= 1'b0;
		end else if (ce_in && s.speed_below) begin
			dir_latch_ff <= s.direction;
		end
	end

	// Shift on oscillator ticks gives one to two periods of dead time
	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			dir_sr_ff <= 2'h0;
		end else if (ce_in && osc_tick) begin
			dir_sr_ff <= {dir_sr_ff[0], dir_latch_ff};
		end
	end

	// A held latch with a differing request keeps the outputs open
	assign dir_mismatch = (s.direction != dir_latch_ff) |
	                      (dir_latch_ff != dir_sr_ff[0]) |
	                      (dir_sr_ff[0] != dir_sr_ff[1]);

	// PWM latch: trip wins over set so a short period cannot glitch on
	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			pwm_on_ff <= 1'b0;
		end else if (ce_in) begin
			if (s.pwm_trip) begin
				pwm_on_ff <= 1'b0;
			end else if (osc_tick) begin
				pwm_on_ff <= 1'b1;
			end
		end
	end

	// Chopping regime is frozen during braking
	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			quad_ff <= 1'b0;
		end else if (ce_in && !brake_active) begin
			quad_ff <= s.quad_select;
		end
	end

	// Soft-start latch; set wins so a standing fault keeps discharge on
	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			discharge_out <= 1'b1;
		end else if (ce_in) begin
			if (s.undervoltage || s.overcurrent) begin
				discharge_out <= 1'b1;
			end else if (s.restart_below) begin
				discharge_out <= 1'b0;
			end
		end
	end

	// Reverse direction equals forward with every position line inverted
	function automatic bcp_roles_t decode(input logic [2:0] h, input logic d);
		bcp_roles_t r;
		r = {BCP_ROLE_HIZ, BCP_ROLE_HIZ, BCP_ROLE_HIZ};
		unique case (d ? h : ~h)
			3'h1: r = {BCP_ROLE_HIZ, BCP_ROLE_SINK, BCP_ROLE_SOURCE};
			3'h3: r = {BCP_ROLE_SINK, BCP_ROLE_HIZ, BCP_ROLE_SOURCE};
			3'h2: r = {BCP_ROLE_SINK, BCP_ROLE_SOURCE, BCP_ROLE_HIZ};
			3'h6: r = {BCP_ROLE_HIZ, BCP_ROLE_SOURCE, BCP_ROLE_SINK};
			3'h4: r = {BCP_ROLE_SOURCE, BCP_ROLE_HIZ, BCP_ROLE_SINK};
			3'h5: r = {BCP_ROLE_SOURCE, BCP_ROLE_SINK, BCP_ROLE_HIZ};
			default: r = {BCP_ROLE_HIZ, BCP_ROLE_HIZ, BCP_ROLE_HIZ};
		endcase
		return r;
	endfunction

	assign roles   = decode(hall_ff, dir_sr_ff[1]);
	assign illegal = (hall_ff == 3'h0) | (hall_ff == 3'h7);

	// Mode priority: coast, brake, open, run
	always_comb begin
		if (s.shutdown_coast || ctrl_ff[`BCP_CTRL_COAST_BIT] ||
		    !ctrl_ff[`BCP_CTRL_ENABLE_BIT]) begin
			mode = BCP_MODE_COAST;
		end else if (brake_active) begin
			mode = BCP_MODE_BRAKE;
		end else if (dir_mismatch || illegal || discharge_out) begin
			mode = BCP_MODE_HIZ;
		end else begin
			mode = BCP_MODE_RUN;
		end
	end

	// Gate enables from mode, roles and chopping regime
	always_comb begin
		nxt_gate = '0;
		unique case (mode)
			BCP_MODE_COAST: nxt_gate = '0;
			BCP_MODE_BRAKE: nxt_gate = '{high: 3'h0, low: 3'h7};
			BCP_MODE_HIZ:   nxt_gate = '0;
			BCP_MODE_RUN: begin
				for (int i = 0; i < 3; i++) begin
					// Half control keeps highs on; full control chops them too
					nxt_gate.high[i] = (roles[i] == BCP_ROLE_SOURCE) &
					                   (quad_ff ? pwm_on_ff : 1'b1);
					nxt_gate.low[i]  = (roles[i] == BCP_ROLE_SINK) & pwm_on_ff;
				end
			end
		endcase
	end

	// Registered gate outputs
	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			gate_out <= '0;
		end else if (ce_in) begin
			gate_out <= nxt_gate;
		end
	end

	// Address phase qualifier; hsize_in is not checked, so any transfer size is taken
	assign addr_ok = hsel_in & htrans_in[1] & hready_in;

	// Read mux; unmapped offsets read as zero
	always_comb begin
		nxt_rdata = 32'h00000000;
		unique case (haddr_in[7:0])
			`BCP_CTRL_OFS:   nxt_rdata = {30'h0, ctrl_ff};
			`BCP_STATUS_OFS: nxt_rdata = {19'h0, mode, discharge_out, pwm_on_ff,
			                              quad_ff, brake_active, tach_out, dir_sr_ff,
			                              dir_latch_ff, hall_ff};
			`BCP_EVENT_OFS:  nxt_rdata = {29'h0, evt_ff};
			default:         nxt_rdata = 32'h00000000;
		endcase
	end

	// Bus slave: zero wait states, OKAY always, data phase writes
	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			hrdata_out    <= 32'h00000000;
			hreadyout_out <= 1'b1;
			hresp_out     <= 1'b0;
			wr_pend_ff    <= 1'b0;
			wr_addr_ff    <= 8'h00;
		end else if (ce_in) begin
			hreadyout_out <= 1'b1;
			hresp_out     <= 1'b0;
			wr_pend_ff    <= addr_ok & hwrite_in;
			if (addr_ok) begin
				wr_addr_ff <= haddr_in[7:0];
				if (!hwrite_in) begin
					hrdata_out <= nxt_rdata;
				end
			end
		end
	end

	// Control register write
	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			ctrl_ff <= `BCP_CTRL_RST;
		end else if (ce_in && wr_pend_ff && wr_addr_ff == `BCP_CTRL_OFS) begin
			ctrl_ff <= hwdata_in[1:0];
		end
	end

	// Events: a set in the clearing cycle survives
	assign evt_clr = (wr_pend_ff && wr_addr_ff == `BCP_EVENT_OFS) ? hwdata_in[2:0] : 3'h0;
	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			evt_ff <= 3'h0;
		end else if (ce_in) begin
			evt_ff <= (evt_ff & ~evt_clr) |
			          {dir_mismatch, s.overcurrent, illegal};
		end
	end

	property p_coast_off;
		@(posedge clock_in) disable iff (!resetn_in)
		ce_in && s.shutdown_coast |=> gate_out == '0;
	endproperty
	a_coast_off: assert property (p_coast_off) else $error("coast left a driver on");
	property p_brake_lows;
		@(posedge clock_in) disable iff (!resetn_in)
		ce_in && brake_active && mode != BCP_MODE_COAST |=>
			gate_out.high == 3'h0 && gate_out.low == 3'h7;
	endproperty
	a_brake_lows: assert property (p_brake_lows) else $error("brake pattern wrong");
	property p_tach_pulse;
		@(posedge clock_in) disable iff (!resetn_in)
		ce_in && tach_start |=> tach_out;
	endproperty
	a_tach_pulse: assert property (p_tach_pulse) else $error("no speed pulse");
	property p_hall_frozen;
		@(posedge clock_in) disable iff (!resetn_in)
		tach_out |=> $stable(hall_ff);
	endproperty
	a_hall_frozen: assert property (p_hall_frozen) else $error("hall moved in pulse");
	property p_dir_hold;
		@(posedge clock_in) disable iff (!resetn_in)
		!s.speed_below |=> $stable(dir_latch_ff);
	endproperty
	a_dir_hold: assert property (p_dir_hold) else $error("direction changed at speed");
	property p_shift_tick;
		@(posedge clock_in) disable iff (!resetn_in)
		!(ce_in && osc_tick) |=> $stable(dir_sr_ff);
	endproperty
	a_shift_tick: assert property (p_shift_tick) else $error("shift without tick");
	property p_softstart_set;
		@(posedge clock_in) disable iff (!resetn_in)
		ce_in && (s.undervoltage || s.overcurrent) |=> discharge_out;
	endproperty
	a_softstart_set: assert property (p_softstart_set) else $error("soft-start not set");
	property p_illegal_open;
		@(posedge clock_in) disable iff (!resetn_in)
		ce_in && illegal && !brake_active |=> gate_out == '0;
	endproperty
	a_illegal_open: assert property (p_illegal_open) else $error("illegal code drove");
	property p_no_shoot;
		@(posedge clock_in) disable iff (!resetn_in)
		(gate_out.high & gate_out.low) == 3'h0;
	endproperty
	a_no_shoot: assert property (p_no_shoot) else $error("phase high and low both on");

endmodule // bcp_commutation

// *** bcp_motor_model.sv ***
/*
 * Model of the Hall sensors and the PWM oscillator in front of the block.
 * Assumes the bench moves the rotor on rising clock edges.
 */
module bcp_motor_model #(
	parameter int OSC_HALF = 8  // Clock cycles per half oscillator period
) (
	// Clock
	input  wire logic       clock_in,
	// Rotor step 0 to 5; 6 and 7 model sensors stuck low or high
	input  wire logic [2:0] step_in,
	// Sensor and oscillator lines
	output logic      [2:0] hall_out,
	output logic            osc_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// Sensors sit 60 degrees apart, so the middle line is inverted
	logic [2:0] seq60 [6] = '{3'h0, 3'h4, 3'h6, 3'h7, 3'h3, 3'h1};
	int         osc_cnt   = 0;  // Half period counter

	initial hall_out = 3'h2;
	initial osc_out = 1'b0;

	// Hall lines follow the rotor one edge later
	always @(posedge clock_in) begin
		if (step_in < 3'h6)
			hall_out <= seq60[step_in] ^ 3'h2;
		else
			hall_out <= (step_in == 3'h6) ? 3'h0 : 3'h7;
	end

	// Oscillator runs free, as an RC oscillator does
	always @(posedge clock_in) begin
		osc_cnt <= (osc_cnt == OSC_HALF - 1) ? 0 : osc_cnt + 1;
		if (osc_cnt == OSC_HALF - 1)
			osc_out <= ~osc_out;
	end
endmodule // bcp_motor_model

// *** bcp_commutation_bench.sv ***
/*
 * Self-checking bench of the commutation block against a behavioural model.
 * Assumes shortened pulse and brake counts so the run stays brief.
 */
module bcp_commutation_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import bcp_pkg::*;
	localparam int TACH = 20;
	localparam int BRK  = 30;
	localparam int OSC  = 8;
	// Clock, reset and pins
	logic        clock_in = 1'b0;
	logic        resetn   = 1'b0;
	logic [2:0]  step     = 3'h0;
	logic        p_dir = 1'b1, p_quad = 1'b1, p_speed = 1'b1, p_brk = 1'b0, p_coast = 1'b0;
	logic        p_uv = 1'b0, p_oc = 1'b0, p_rst = 1'b0, p_trip = 1'b0;
	logic [2:0]  hall;
	logic        osc;
	bcp_pins_t   pins;
	// Bus and outputs
	logic        hsel = 1'b0, hwrite = 1'b0, hready;
	logic [1:0]  htrans = 2'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
	bcp_gate_t   gate;
	logic        tach, dis, hresp;
	// Model state: mode 0 run, 1 brake, 2 all off
	int          m_step = 0, m_dir = 1, m_quad = 1, m_pwm = 1, m_mode = 0;
	int          error_cnt = 0;
	int          checks = 0;
	integer      seed = 32'hbf2c0ae0;
	// Step to code, and source and sink phase per code for direction 1
	logic [2:0]  hall_of [8] = '{3'h2, 3'h6, 3'h4, 3'h5, 3'h1, 3'h3, 3'h0, 3'h7};
	int          src_of [8] = '{0, 0, 1, 0, 2, 2, 1, 0};
	int          snk_of [8] = '{0, 1, 2, 2, 0, 1, 0, 0};

	always #5 clock_in = ~clock_in;
	assign pins = {hall, p_dir, p_quad, p_speed, p_brk, p_coast, p_uv, p_oc, p_rst, p_trip, osc};

	bcp_motor_model #(.OSC_HALF(OSC)) i_motor (.clock_in(clock_in), .step_in(step),
		.hall_out(hall), .osc_out(osc));

	bcp_commutation #(.TACH_CYCLES(16'(TACH)), .BRAKE_CYCLES(16'(BRK))) i_dut (
		.clock_in(clock_in), .resetn_in(resetn), .ce_in(1'b1), .pins_in(pins),
		.hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
		.hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata),
		.hreadyout_out(hready), .hresp_out(hresp), .gate_out(gate), .tach_out(tach),
		.discharge_out(dis));

	// Expected gates; a reversed direction swaps source and sink
	function automatic bcp_gate_t exp_gate();
		bcp_gate_t   g;
		int          src;
		int          snk;
		logic [2:0]  h;
		g = '0;
		h = hall_of[m_step];
		if (m_mode == 1)
			g.low = 3'h7;
		else if (m_mode == 0 && h != 3'h0 && h != 3'h7) begin
			src = m_dir ? src_of[h] : snk_of[h];
			snk = m_dir ? snk_of[h] : src_of[h];
			g.high[src] = m_quad ? 1'(m_pwm) : 1'b1;
			g.low[snk] = 1'(m_pwm);
		end
		return g;
	endfunction

	task automatic cyc(input int n);
		repeat (n) @(posedge clock_in);
	endtask

	task automatic fail(input string msg);
		error_cnt++;
		$display("FAIL %0t %s", $time, msg);
	endtask

	// Gate and discharge are looked at mid-cycle, where they are settled
	task automatic cmp_gate(input bcp_gate_t e);
		@(negedge clock_in);
		checks++;
		if (gate !== e)
			fail($sformatf("gate %h want %h", gate, e));
		@(posedge clock_in);
	endtask

	task automatic cmp_dis(input logic e);
		@(negedge clock_in);
		checks++;
		if (dis !== e)
			fail("discharge level wrong");
		@(posedge clock_in);
	endtask

	task automatic cmp_word(input logic [31:0] got, input logic [31:0] e);
		checks++;
		if (got !== e)
			fail($sformatf("word %h want %h", got, e));
	endtask

	// One AHB-Lite single transfer, entered just after a rising edge
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
			output logic [31:0] rd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= wr;
		// No wait is bounded here; only the watchdog ends a stalled transfer
		do begin
			@(posedge clock_in);
		end while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do begin
			@(posedge clock_in);
		end while (hready !== 1'b1);
		rd = hrdata;
		if (hresp !== 1'b0)
			fail("bus answered with an error");
	endtask

	// Counts the cycles of the next speed pulse, bounded
	task automatic tach_len(output int len);
		int n;
		n = 0;
		len = 0;
		while (tach !== 1'b1 && n < 200) begin
			@(posedge clock_in);
			n++;
		end
		while (tach === 1'b1 && len < 200) begin
			@(posedge clock_in);
			len++;
		end
	endtask

	task automatic report_and_stop();
		$display("errors %0d checks %0d", error_cnt, checks);
		if (error_cnt == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Watchdog: the sequence needs about a thousand cycles
	initial begin
		cyc(20000);
		fail("timeout");
		report_and_stop();
	end

	// Main sequence
	initial begin
		logic [31:0] rd;
		int          len;
		int          s;
		int          walk[$];
		cyc(4);
		resetn <= 1'b1;
		cyc(3);
		cmp_gate(6'h07);
		cmp_dis(1'b1);
		ahb(1'b0, 8'h00, 32'h0, rd);
		cmp_word(rd, 32'h1);
		ahb(1'b0, 8'h40, 32'h0, rd);
		cmp_word(rd, 32'h0);
		m_mode = 2;
		cyc(60);
		cmp_gate(exp_gate());
		p_rst <= 1'b1;
		m_mode = 0;
		cyc(6);
		cmp_dis(1'b0);
		// Full turn in each direction, reversal in between
		for (int d = 1; d >= 0; d--) begin
			if (d == 0) begin
				p_speed <= 1'b0;
				p_dir <= 1'b0;
				cyc(10);
				cmp_gate(6'h00);
				ahb(1'b0, 8'h04, 32'h0, rd);
				cmp_word({31'h0, rd[3]}, 32'h1);
				p_speed <= 1'b1;
				cyc(5);
				cmp_gate(6'h00);
				m_dir = 0;
				cyc(60);
				cmp_gate(exp_gate());
			end
			for (int i = 1; i <= 6; i++) begin
				m_step = i % 6;
				step <= 3'(m_step);
				tach_len(len);
				cmp_word(32'(len), 32'(TACH));
				cmp_gate(exp_gate());
			end
		end
		// Hall change during the pulse waits for its end
		m_step = 1;
		step <= 3'h1;
		cyc(8);
		step <= 3'h2;
		cyc(6);
		cmp_gate(exp_gate());
		m_step = 2;
		cyc(2 * TACH + 10);
		cmp_gate(exp_gate());
		// Chopping regimes
		p_trip <= 1'b1;
		m_pwm = 0;
		cyc(8);
		cmp_gate(exp_gate());
		p_quad <= 1'b0;
		m_quad = 0;
		cyc(8);
		cmp_gate(exp_gate());
		p_trip <= 1'b0;
		m_pwm = 1;
		cyc(3 * OSC);
		cmp_gate(exp_gate());
		p_quad <= 1'b1;
		m_quad = 1;
		// Full control must be in effect before braking freezes the select
		cyc(8);
		cmp_gate(exp_gate());
		// Brake, select ignored meanwhile
		p_brk <= 1'b1;
		m_mode = 1;
		cyc(8);
		cmp_gate(exp_gate());
		p_quad <= 1'b0;
		cyc(8);
		ahb(1'b0, 8'h04, 32'h0, rd);
		cmp_word({31'h0, rd[8]}, 32'h1);
		p_brk <= 1'b0;
		m_mode = 0;
		cyc(8);
		ahb(1'b0, 8'h04, 32'h0, rd);
		cmp_word({31'h0, rd[8]}, 32'h0);
		p_quad <= 1'b1;
		// Coast from the pin, then from software
		p_coast <= 1'b1;
		m_mode = 2;
		cyc(8);
		cmp_gate(exp_gate());
		p_coast <= 1'b0;
		cyc(8);
		ahb(1'b1, 8'h00, 32'h3, rd);
		cyc(2);
		cmp_gate(exp_gate());
		ahb(1'b1, 8'h00, 32'h1, rd);
		m_mode = 0;
		cyc(8);
		cmp_gate(exp_gate());
		// Faults set soft-start; restart needs low capacitor and no fault
		p_oc <= 1'b1;
		m_mode = 2;
		cyc(8);
		cmp_dis(1'b1);
		cmp_gate(exp_gate());
		ahb(1'b0, 8'h08, 32'h0, rd);
		cmp_word({31'h0, rd[1]}, 32'h1);
		p_oc <= 1'b0;
		p_rst <= 1'b0;
		cyc(8);
		cmp_dis(1'b1);
		p_rst <= 1'b1;
		cyc(8);
		cmp_dis(1'b0);
		ahb(1'b1, 8'h08, 32'h2, rd);
		ahb(1'b0, 8'h08, 32'h0, rd);
		cmp_word({31'h0, rd[1]}, 32'h0);
		p_uv <= 1'b1;
		cyc(8);
		cmp_dis(1'b1);
		p_uv <= 1'b0;
		m_mode = 0;
		cyc(8);
		cmp_dis(1'b0);
		// Random walk of the rotor, one sensor changing at a time
		s = m_step;
		repeat (8) begin
			s = ($random(seed) & 1) ? (s + 1) % 6 : (s + 5) % 6;
			walk.push_back(s);
		end
		foreach (walk[k]) begin
			m_step = walk[k];
			step <= 3'(m_step);
			cyc(TACH + 10);
			cmp_gate(exp_gate());
		end
		// Stuck sensors give illegal codes
		for (int c = 6; c <= 7; c++) begin
			m_step = c;
			step <= 3'(c);
			cyc(TACH + 10);
			cmp_gate(exp_gate());
		end
		report_and_stop();
	end
endmodule // bcp_commutation_bench
